// ### verilog/can_irq_timing_pkg.sv
/*
 * constants shared by the interrupt prioritiser and bit timing block:
 * register offsets, field positions, reset values and segment states.
 * assumes a 32-bit AHB-Lite register port and 32 message objects.
 */
package can_irq_timing_pkg;
   localparam int NUM_OBJECTS = 32;
   // register byte offsets
   localparam logic [11:0] OFS_CONTROL = 12'h000;
   localparam logic [11:0] OFS_STATUS = 12'h004;
   localparam logic [11:0] OFS_BIT_TIMING = 12'h00C;
   localparam logic [11:0] OFS_IRQ_ID = 12'h010;
   localparam logic [11:0] OFS_CMD_REQUEST = 12'h020;
   localparam logic [11:0] OFS_CMD_MASK = 12'h024;
   localparam logic [11:0] OFS_PENDING_LO = 12'h140;
   localparam logic [11:0] OFS_PENDING_HI = 12'h144;
   // reset values
   localparam logic [3:0] CONTROL_RESET = 4'h1;
   localparam logic [14:0] BIT_TIMING_RESET = 15'h2301;
   // control fields
   localparam int CTL_INIT = 0;
   localparam int CTL_IE = 1;
   localparam int CTL_SIE = 2;
   localparam int CTL_EIE = 3;
   // status fields
   localparam int STS_TRANSMIT_SUCCESS_FLAG = 3;
   localparam int STS_RECEIVE_SUCCESS_FLAG = 4;
   // command mask field
   localparam int CMSK_CLR_PEND = 3;
   // bit timing fields
   localparam int BT_BRP_LSB = 0;
   localparam int BT_SJW_LSB = 6;
   localparam int BT_PRE_SAMPLE_LENGTH_LSB = 8;
   localparam int BT_POST_SAMPLE_LENGTH_LSB = 12;
   // identifier values
   localparam logic [15:0] ID_NONE = 16'h0000;
   localparam logic [15:0] ID_STATUS = 16'h8000;
   // processing delay after the sample point, in quanta
   localparam int POST_SAMPLE_PROCESSING_DELAY = 0;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   typedef enum logic [2:0] {
      SEG_SYNC = 3'b001,
      SEG_PH1 = 3'b010,
      SEG_PH2 = 3'b100
   } seg_state_t;
endpackage

// ### verilog/can_irq_timing.sv
/*
 * interrupt prioritiser and bit timing logic of a CAN controller, with an
 * AHB-Lite register slave. assumes the message handler pulses per-object
 * pending sets and status updates, and that can_rx is synchronous to clk.
 */
module can_irq_timing (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // message handler and status events
   input wire logic [can_irq_timing_pkg::NUM_OBJECTS-1:0] obj_irq_set,
   input wire logic status_update,
   input wire logic [2:0] status_lec,
   input wire logic status_transmit_success_flag,
   input wire logic status_receive_success_flag,
   // can bus side
   input wire logic can_rx,
   output logic sample_strobe,
   output logic sampled_bit,
   // processor interrupt
   output logic irq
);
   import can_irq_timing_pkg::*;

   logic [3:0] control_register;
   logic [4:0] bus_status_register;
   logic [14:0] bit_timing_register;
   logic [3:0] transfer_command_mask;
   logic [NUM_OBJECTS-1:0] object_irq_pending;
   logic status_pending;
   logic [15:0] irq_cause_code;
   logic [15:0] next_cause;
   logic wr_pend;
   logic [11:0] wr_addr;
   logic rd_take;
   logic wr_take;
   logic [NUM_OBJECTS-1:0] clr_vec;
   logic [31:0] rd_mux;

   // lowest-numbered pending object, coded as its object number
   function automatic logic [15:0] first_pending(input logic [NUM_OBJECTS-1:0] v);
      logic [15:0] r;
      r = ID_NONE;
      for (int i = NUM_OBJECTS - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = 16'(i + 1);
         end
      end
      return r;
   endfunction

   // functional length from a minus-one field
   function automatic logic [4:0] plus_one(input logic [3:0] f);
      return {1'b0, f} + 5'h01;
   endfunction

   assign rd_take = hsel && hready && (htrans == HTRANS_NONSEQ) && !hwrite;
   assign wr_take = hsel && hready && (htrans == HTRANS_NONSEQ) && hwrite;

   // bus answers every transfer with zero wait states and OKAY
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         hreadyout <= 1'b0;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // write address phase is held for the following data phase
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wr_pend <= 1'b0;
         wr_addr <= 12'h000;
      end else begin
         wr_pend <= wr_take;
         if (wr_take) begin
            wr_addr <= haddr;
         end
      end
   end

   // read data is latched at the address phase so it stands in the data phase
   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (haddr)
         OFS_CONTROL: rd_mux = {28'h0000000, control_register};
         OFS_STATUS: rd_mux = {27'h0000000, bus_status_register};
         OFS_BIT_TIMING: rd_mux = {17'h00000, bit_timing_register};
         OFS_IRQ_ID: rd_mux = {16'h0000, irq_cause_code};
         OFS_CMD_MASK: rd_mux = {28'h0000000, transfer_command_mask};
         OFS_PENDING_LO: rd_mux = {16'h0000, object_irq_pending[15:0]};
         OFS_PENDING_HI: rd_mux = {16'h0000, object_irq_pending[31:16]};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         hrdata <= 32'h0000_0000;
      end else if (rd_take) begin
         hrdata <= rd_mux;
      end
   end

   // software-written configuration
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         control_register <= CONTROL_RESET;
         bit_timing_register <= BIT_TIMING_RESET;
         transfer_command_mask <= 4'h0;
      end else if (wr_pend) begin
         unique case (wr_addr)
            OFS_CONTROL: control_register <= hwdata[3:0];
            OFS_BIT_TIMING: bit_timing_register <= hwdata[14:0];
            OFS_CMD_MASK: transfer_command_mask <= hwdata[3:0];
            default: ;
         endcase
      end
   end

   // status flags: hardware update wins over a software write in the same cycle
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         bus_status_register <= 5'h00;
      end else if (status_update) begin
         bus_status_register <= {status_receive_success_flag, status_transmit_success_flag, status_lec};
      end else if (wr_pend && wr_addr == OFS_STATUS) begin
         bus_status_register <= hwdata[4:0];
      end
   end

   // status interrupt source: only a read clears it, a new update wins
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         status_pending <= 1'b0;
      end else if (status_update && control_register[CTL_SIE]) begin
         status_pending <= 1'b1;
      end else if (rd_take && haddr == OFS_STATUS) begin
         status_pending <= 1'b0;
      end
   end

   // a read transfer request names an object; its pending flag drops if asked
   always_comb begin
      clr_vec = '0;
      if (wr_pend && wr_addr == OFS_CMD_REQUEST && transfer_command_mask[CMSK_CLR_PEND]) begin
         for (int i = 0; i < NUM_OBJECTS; i++) begin
            if (hwdata[5:0] == 6'(i + 1)) begin
               clr_vec[i] = 1'b1;
            end
         end
      end
   end

   // sticky pending flags; a set in the clearing cycle is kept
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         object_irq_pending <= '0;
      end else begin
         object_irq_pending <= (object_irq_pending & ~clr_vec) | obj_irq_set;
      end
   end

   // priority: status first, then lowest object number, whatever the enable
   always_comb begin
      next_cause = first_pending(object_irq_pending);
      if (status_pending) begin
         next_cause = ID_STATUS;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         irq_cause_code <= ID_NONE;
      end else begin
         irq_cause_code <= next_cause;
      end
   end

   // line follows the registered identifier, costing one cycle of latency
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         irq <= 1'b0;
      end else begin
         irq <= control_register[CTL_IE] && (irq_cause_code != ID_NONE);
      end
   end

   // bit timing
   logic [5:0] psc_cnt;
   logic tq_tick;
   logic [4:0] pre_sample_length_len;
   logic [4:0] post_sample_length_len;
   logic [4:0] sjw_len;
   logic [5:0] brp_field;
   seg_state_t seg_state;
   logic [4:0] q_cnt;
   logic [4:0] seg_end;
   logic resync_done;
   logic rx_prev;
   logic rx_edge;
   logic [4:0] p_err;
   logic [4:0] remain;

   assign brp_field = bit_timing_register[BT_SJW_LSB-1:BT_BRP_LSB];
   assign sjw_len = plus_one({2'h0, bit_timing_register[BT_PRE_SAMPLE_LENGTH_LSB-1:BT_SJW_LSB]});
   assign pre_sample_length_len = plus_one(bit_timing_register[BT_POST_SAMPLE_LENGTH_LSB-1:BT_PRE_SAMPLE_LENGTH_LSB]);
   assign post_sample_length_len = plus_one({1'b0, bit_timing_register[14:BT_POST_SAMPLE_LENGTH_LSB]});
   assign rx_edge = rx_prev && !can_rx;
   assign p_err = (q_cnt < sjw_len) ? q_cnt : sjw_len;
   assign remain = seg_end - q_cnt + 5'h01;

   // prescaler: one tick every brp+1 clocks; halted while init is set
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         psc_cnt <= 6'h00;
         tq_tick <= 1'b0;
      end else if (control_register[CTL_INIT]) begin
         psc_cnt <= 6'h00;
         tq_tick <= 1'b0;
      end else begin
         tq_tick <= (psc_cnt == brp_field);
         psc_cnt <= (psc_cnt == brp_field) ? 6'h00 : psc_cnt + 6'h01;
      end
   end

   // bus level seen at the previous quantum, for edge detection
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rx_prev <= 1'b1;
      end else if (tq_tick) begin
         rx_prev <= can_rx;
      end
   end

   // segment sequencer, stepped only on quantum ticks
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         seg_state <= SEG_SYNC;
         q_cnt <= 5'h00;
         seg_end <= 5'h01;
         resync_done <= 1'b0;
      end else if (control_register[CTL_INIT]) begin
         seg_state <= SEG_SYNC;
         q_cnt <= 5'h00;
         resync_done <= 1'b0;
      end else if (tq_tick) begin
         unique case (seg_state)
            SEG_SYNC: begin
               seg_state <= SEG_PH1;
               q_cnt <= 5'h01;
               seg_end <= pre_sample_length_len;
               resync_done <= 1'b0;
            end
            SEG_PH1: begin
               if (q_cnt == seg_end && !(rx_edge && !resync_done)) begin
                  seg_state <= SEG_PH2;
                  q_cnt <= 5'h01;
                  seg_end <= post_sample_length_len;
               end else begin
                  // late edge: stretch the first phase by the phase error, capped
                  if (rx_edge && !resync_done) begin
                     seg_end <= seg_end + p_err;
                     resync_done <= 1'b1;
                  end
                  q_cnt <= q_cnt + 5'h01;
               end
            end
            SEG_PH2: begin
               if (rx_edge && !resync_done && remain <= sjw_len) begin
                  // early edge within reach: it becomes the next bit's sync
                  seg_state <= SEG_PH1;
                  q_cnt <= 5'h01;
                  seg_end <= pre_sample_length_len;
               end else if (rx_edge && !resync_done) begin
                  seg_end <= seg_end - sjw_len;
                  resync_done <= 1'b1;
                  q_cnt <= q_cnt + 5'h01;
               end else if (q_cnt >= seg_end) begin
                  seg_state <= SEG_SYNC;
               end else begin
                  q_cnt <= q_cnt + 5'h01;
               end
            end
         endcase
      end
   end

   // sampled bit handed to the protocol engine at the end of the first phase
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sample_strobe <= 1'b0;
         sampled_bit <= 1'b1;
      end else begin
         sample_strobe <= tq_tick && seg_state == SEG_PH1 && q_cnt == seg_end && !(rx_edge && !resync_done);
         if (tq_tick && seg_state == SEG_PH1 && q_cnt == seg_end && !(rx_edge && !resync_done)) begin
            sampled_bit <= can_rx;
         end
      end
   end

   // helper: clocks between quantum ticks, and quanta in an undisturbed bit
   logic [6:0] gap_cnt;
   logic [5:0] bit_q;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         gap_cnt <= 7'h00;
         bit_q <= 6'h00;
      end else if (control_register[CTL_INIT]) begin
         // sequencer restarts after init, so counts from before it must not be judged
         gap_cnt <= 7'h00;
         bit_q <= 6'h00;
      end else begin
         gap_cnt <= tq_tick ? 7'h01 : gap_cnt + 7'h01;
         if (tq_tick) begin
            // an early edge in the second phase starts a new bit just like a sync quantum
            bit_q <= (seg_state == SEG_SYNC || (seg_state == SEG_PH2 && rx_edge && !resync_done &&
               remain <= sjw_len)) ? 6'h01 : bit_q + 6'h01;
         end
      end
   end

   sequence seq_sync_tick;
      tq_tick && seg_state == SEG_SYNC && !control_register[CTL_INIT];
   endsequence
   sequence seq_enter_ph1;
      ##1 seg_state == SEG_PH1 && q_cnt == 5'h01;
   endsequence

   chk_status_first: assert property (@(posedge clk) disable iff (!rstn)
      status_pending |=> irq_cause_code == ID_STATUS) else $error("status not reported first");
   chk_lowest_object: assert property (@(posedge clk) disable iff (!rstn)
      !status_pending && object_irq_pending[0] |=> irq_cause_code == 16'h0001)
      else $error("object one not reported");
   chk_idle_zero: assert property (@(posedge clk) disable iff (!rstn)
      !status_pending && object_irq_pending == '0 |=> irq_cause_code == ID_NONE)
      else $error("identifier nonzero while idle");
   chk_irq_line: assert property (@(posedge clk) disable iff (!rstn)
      ##1 irq == ($past(control_register[CTL_IE]) && $past(irq_cause_code) != ID_NONE))
      else $error("interrupt line wrong");
   chk_pending_sticky: assert property (@(posedge clk) disable iff (!rstn)
      ##1 (($past(object_irq_pending) & ~$past(clr_vec) & ~object_irq_pending) == '0))
      else $error("pending flag dropped");
   chk_status_enable: assert property (@(posedge clk) disable iff (!rstn)
      status_update && !control_register[CTL_SIE] && !status_pending |=> !status_pending)
      else $error("status interrupt while disabled");
   chk_status_read: assert property (@(posedge clk) disable iff (!rstn)
      rd_take && haddr == OFS_STATUS && !status_update ##1 !wr_pend |-> !status_pending)
      else $error("status read did not clear");
   chk_quantum_len: assert property (@(posedge clk) disable iff (!rstn)
      tq_tick && $past(tq_tick) == 1'b0 && $stable(brp_field) && gap_cnt > 7'h01 |->
      gap_cnt == {1'b0, brp_field} + 7'h01) else $error("quantum length wrong");
   chk_sync_one: assert property (@(posedge clk) disable iff (!rstn)
      seq_sync_tick |-> seq_enter_ph1) else $error("sync segment not one quantum");
   chk_bit_length: assert property (@(posedge clk) disable iff (!rstn)
      seq_sync_tick and (!resync_done && bit_q > 6'h00 && $stable(bit_timing_register)) |->
      bit_q == 6'(pre_sample_length_len) + 6'(post_sample_length_len) + 6'h01) else $error("bit length wrong");
endmodule

// ### test/can_bus_node.sv
/*
 * far-side node model: drives the bus level seen at can_rx with a bit
 * stream of its own period, recessive whenever it is not sending.
 * assumes the bench hands it a bit length in module clocks and a pattern.
 */
module can_bus_node (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // control from the bench
   input wire logic en,
   input wire logic [9:0] bit_clocks,
   input wire logic [31:0] pattern,
   // bus level and the bit being sent
   output logic can_rx,
   output logic cur_bit
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [9:0] cnt;
   logic [5:0] idx;
   // own bit clock, free of the device, so its phase drifts against it
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt <= 10'h000;
         idx <= 6'h00;
      end else if (!en) begin
         cnt <= 10'h000;
         idx <= 6'h00;
      end else if (cnt == bit_clocks - 10'h001) begin
         cnt <= 10'h000;
         idx <= idx + 6'h01;
      end else begin
         cnt <= cnt + 10'h001;
      end
   end
   // even bits recessive so a falling edge comes at most every other bit
   assign cur_bit = idx[0] ? pattern[idx[4:0]] : 1'b1;
   // released bus floats recessive, there is no dominant idle state
   assign can_rx = en ? cur_bit : 1'b1;
endmodule

// ### test/can_irq_priority_and_bit_timing_bench.sv
/*
 * self-checking bench for the interrupt prioritiser and bit timing block:
 * an AHB-Lite master, a model of pending causes, and a far-side node.
 * assumes zero wait states on the register port and a 50 MHz clock.
 */
module can_irq_priority_and_bit_timing_bench;
   import can_irq_timing_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rstn, hsel, hwrite, hready, hreadyout, hresp, irq;
   logic [11:0] haddr;
   logic [1:0] htrans;
   logic [2:0] hsize, status_lec;
   logic [31:0] hwdata, hrdata, obj_irq_set, pattern;
   logic status_update, status_transmit_success_flag, status_receive_success_flag;
   logic can_rx, sample_strobe, sampled_bit, node_en, cur_bit;
   logic [9:0] bit_clocks;
   logic [31:0] seed = 32'h0000F488;
   logic [31:0] pend_m, sts_m, bt;
   logic stat_m, ie_m, sie_m;
   logic [3:0] ctl_tab [3] = '{4'h7, 4'h1, 4'h3};
   int per_tab [3] = '{18, 19, 17};
   int err_total = 0;
   int total_checks = 0;
   int n, e;
   // one slave, so its ready is the bus ready
   assign hready = hreadyout;
   can_irq_timing dut (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hready(hready), .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .obj_irq_set(obj_irq_set), .status_update(status_update), .status_lec(status_lec),
      .status_transmit_success_flag(status_transmit_success_flag), .status_receive_success_flag(status_receive_success_flag), .can_rx(can_rx), .sample_strobe(sample_strobe),
      .sampled_bit(sampled_bit), .irq(irq));
   can_bus_node node (.clk(clk), .rstn(rstn), .en(node_en), .bit_clocks(bit_clocks), .pattern(pattern),
      .can_rx(can_rx), .cur_bit(cur_bit));
   // free-running module clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // status first, then the lowest numbered pending object
   function automatic logic [31:0] exp_id();
      if (stat_m) return {16'h0000, ID_STATUS};
      for (int i = 0; i < NUM_OBJECTS; i++) if (pend_m[i]) return 32'(i + 1);
      return 32'h00000000;
   endfunction
   task automatic conclude();
      if (err_total == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // bounded wait for ready, so a stuck slave ends the run
   task automatic ready_edge();
      int k;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (hready !== 1'b1 && k < 50);
      if (k >= 50) begin
         err_total++;
         conclude();
      end
   endtask
   // one single word transfer: address phase, then data phase
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      haddr <= a;
      hwrite <= w;
      hsize <= 3'h2;
      ready_edge();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      ready_edge();
      q = hrdata;
      check({31'h0, hresp}, 32'h00000000);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h00000000, q);
      check(q, exp);
   endtask
   task automatic ctl(input logic [3:0] v);
      wr(OFS_CONTROL, {28'h0, v});
      ie_m = v[CTL_IE];
      sie_m = v[CTL_SIE];
   endtask
   task automatic obj_set(input logic [31:0] m);
      @(posedge clk);
      obj_irq_set <= m;
      @(posedge clk);
      obj_irq_set <= 32'h00000000;
      pend_m |= m;
   endtask
   task automatic stat_evt();
      logic [31:0] r;
      r = rnd();
      @(posedge clk);
      status_update <= 1'b1;
      status_lec <= r[2:0];
      status_transmit_success_flag <= r[3];
      status_receive_success_flag <= r[4];
      @(posedge clk);
      status_update <= 1'b0;
      sts_m = {27'h0, r[4:0]};
      if (sie_m) stat_m = 1'b1;
   endtask
   task automatic verify();
      repeat (4) @(posedge clk);
      check({31'h0, irq}, {31'h0, ie_m && exp_id() != 32'h0});
      rdchk(OFS_IRQ_ID, exp_id());
      rdchk(OFS_PENDING_LO, {16'h0, pend_m[15:0]});
      rdchk(OFS_PENDING_HI, {16'h0, pend_m[31:16]});
   endtask
   task automatic clear_obj(input logic clr);
      int num;
      num = int'(exp_id());
      wr(OFS_CMD_MASK, clr ? 32'h1 << CMSK_CLR_PEND : 32'h0);
      wr(OFS_CMD_REQUEST, 32'(num));
      if (clr) pend_m[num - 1] = 1'b0;
   endtask
   task automatic wait_strobe(output int k);
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (sample_strobe !== 1'b1 && k < 2000);
      if (k >= 2000) begin
         err_total++;
         conclude();
      end
   endtask
   // main sequence: registers, interrupt causes, then bit timing
   initial begin
      {hsel, hwrite, status_update, status_transmit_success_flag, status_receive_success_flag, node_en} = 6'h00;
      haddr = 12'h000;
      htrans = 2'h0;
      hsize = 3'h2;
      status_lec = 3'h0;
      hwdata = 32'h0;
      obj_irq_set = 32'h0;
      pattern = 32'h0;
      bit_clocks = 10'h012;
      {pend_m, sts_m, stat_m, ie_m, sie_m} = '0;
      rstn = 1'b0;
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      repeat (2) @(posedge clk);
      rdchk(OFS_CONTROL, 32'h00000001);
      rdchk(OFS_BIT_TIMING, 32'h00002301);
      rdchk(OFS_IRQ_ID, 32'h00000000);
      rdchk(OFS_STATUS, 32'h00000000);
      wr(12'h008, 32'hFFFFFFFF);
      rdchk(12'h008, 32'h00000000);
      ctl(4'hF);
      rdchk(OFS_CONTROL, 32'h0000000F);
      for (int k = 0; k < 3; k++) begin
         // an urgent object arriving later must still win
         obj_set(rnd() & 32'hFFFF0000);
         obj_set(rnd() & 32'h0000FFFF);
         ctl(ctl_tab[k]);
         verify();
         stat_evt();
         verify();
         rdchk(OFS_STATUS, sts_m);
         stat_m = 1'b0;
         verify();
         // a write leaves the status cause pending
         stat_evt();
         wr(OFS_STATUS, 32'h0);
         verify();
         rdchk(OFS_STATUS, 32'h0);
         stat_m = 1'b0;
         clear_obj(1'b0);
         verify();
         // keep one cause pending into the next round's enable change
         while ((pend_m & (pend_m - 32'h1)) != 32'h0) begin
            clear_obj(1'b1);
            verify();
         end
      end
      // idle bus: strobe spacing is the whole bit
      for (int k = 0; k < 3; k++) begin
         // prescaler kept within 1..32, jump width 1, pre-sample at least two quanta
         bt = (rnd() & 32'h00007F1F) | 32'h00000100;
         ctl(4'h1);
         wr(OFS_BIT_TIMING, bt);
         rdchk(OFS_BIT_TIMING, bt);
         ctl(4'h0);
         e = (int'(bt[5:0]) + 1) * (int'(bt[11:8]) + int'(bt[14:12]) + 3);
         wait_strobe(n);
         wait_strobe(n);
         check(32'(n), 32'(e));
      end
      // traffic from a node at nominal, slow and fast bit rate
      ctl(4'h1);
      // jump width 3 stays within both phase segments
      wr(OFS_BIT_TIMING, 32'h00003381);
      ctl(4'h0);
      for (int k = 0; k < 3; k++) begin
         @(posedge clk);
         // every fourth bit dominant, so a resync edge comes at least every four bits
         pattern <= rnd() & 32'h77777777;
         bit_clocks <= 10'(per_tab[k]);
         node_en <= 1'b1;
         repeat (4) wait_strobe(n);
         for (int b = 0; b < 24; b++) begin
            wait_strobe(n);
            check({31'h0, sampled_bit}, {31'h0, cur_bit});
         end
         node_en <= 1'b0;
         repeat (40) @(posedge clk);
      end
      conclude();
   end
endmodule
